/* core/rsi_status.v */
// Rectifier status indicator: maps condition inputs to the three front lamps
// and the active-low open-drain monitoring lines, with an AHB-Lite slave.
// Assumes condition inputs may be asynchronous; one clock hclk at 20 MHz.
//
// Contract
// - Thermal alarm: fault lamp blinks, good lamps on, fault and warning high.
// - Shutdown faults: input and fault lamps on, output lamp off, both lines low.
// - Input out of limits: input lamp blinks, others off, both lines high.
// - Input absent: all lamps off, fault high, warning low.
// - Overload: output lamp blinks, input on, warning pulses at 1 ms.
// - Non-stopping fault: all lamps on, fault low, warning high.
// - Output on only while remote input grounded; else standby indication. Here input out of limits outranks standby and leaves the output on.
// - Warning goes low about 5 ms before the output drops.
// - Internal-failure line high normally, low on internal failure.
// - Fault, warning, over-temperature and capacity lines are open-drain, pull low only.
// - Presence line is held low while the module is inserted.
`timescale 1ns/1ns
`include "rsi_defines.vh"

module rsi_status #(
  parameter WARN_LEAD_CYC = `RSI_WARN_LEAD_US * (`RSI_CLK_HZ / 1000000),
  parameter PULSE_CYC = `RSI_PULSE_US * (`RSI_CLK_HZ / 1000000),
  parameter BLINK_HALF_CYC = `RSI_BLINK_HALF_MS * (`RSI_CLK_HZ / 1000)
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave.
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // Condition inputs, active high except the remote on/off line.
  input wire thermal_alarm,
  input wire thermal_shutdown,
  input wire fan_fail,
  input wire fuse_blown,
  input wire boost_fail,
  input wire ov_latched,
  input wire input_out_of_limits,
  input wire input_absent,
  input wire overload,
  input wire noncat_fail,
  input wire remote_on_off_n,
  // Front panel lamps, high is lit.
  output reg input_good_lamp,
  output reg output_good_lamp,
  output reg fault_lamp,
  // Open-drain monitoring lines: out value and output enable.
  output reg fault_n_o,
  output reg fault_n_oe,
  output reg power_fail_warning_n_o,
  output reg power_fail_warning_n_oe,
  output reg over_temp_warning_n_o,
  output reg over_temp_warning_n_oe,
  output reg power_capacity_n_o,
  output reg power_capacity_n_oe,
  output reg module_present_n_o,
  output reg module_present_n_oe,
  // Main output enable toward the power stage.
  output reg main_output_on
);

  // ---------------------------------------------------------------------------
  // Indication states: ST_OK, then the others most severe first.
  // ---------------------------------------------------------------------------
  localparam [2:0] ST_OK = 3'h0;
  localparam [2:0] ST_ABSENT = 3'h1;
  localparam [2:0] ST_SHDN = 3'h2;
  localparam [2:0] ST_LIMITS = 3'h3;
  localparam [2:0] ST_STBY = 3'h4;
  localparam [2:0] ST_NONCAT = 3'h5;
  localparam [2:0] ST_OVLD = 3'h6;
  localparam [2:0] ST_TALARM = 3'h7;

  wire [`RSI_NCOND-1:0] cond_raw;
  reg [`RSI_NCOND-1:0] cond_q;
  wire blink;
  wire pulse;
  reg [31:0] ctrl_q;
  reg [2:0] state_d;
  reg [2:0] state_q;
  reg [31:0] lead_cnt_q;
  reg stop_req;
  reg in_lamp_d;
  reg out_lamp_d;
  reg flt_lamp_d;
  reg fault_low_d;
  reg warn_low_d;
  reg wr_pend_q;
  reg [11:0] wr_addr_q;
  reg [31:0] rd_mux;
  wire remote_off;
  wire hot_low;
  wire addr_acc;
  wire [31:0] ind_word;

  assign cond_raw[`RSI_C_THERM_ALARM] = thermal_alarm;
  assign cond_raw[`RSI_C_THERM_SHDN] = thermal_shutdown;
  assign cond_raw[`RSI_C_FAN_FAIL] = fan_fail;
  assign cond_raw[`RSI_C_FUSE_BLOWN] = fuse_blown;
  assign cond_raw[`RSI_C_BOOST_FAIL] = boost_fail;
  assign cond_raw[`RSI_C_OV_LATCH] = ov_latched;
  assign cond_raw[`RSI_C_IN_LIMITS] = input_out_of_limits;
  assign cond_raw[`RSI_C_IN_ABSENT] = input_absent;
  assign cond_raw[`RSI_C_OVERLOAD] = overload;
  assign cond_raw[`RSI_C_NONCAT] = noncat_fail;
  assign cond_raw[`RSI_C_REMOTE_OFF_N] = remote_on_off_n;

  // ---------------------------------------------------------------------------
  // Input synchronisers.
  // ---------------------------------------------------------------------------
  // Three flops per input; a change is taken only when the second and third
  // agree, which also rejects a single-cycle glitch on the pins.
  genvar gi;
  generate
    for (gi = 0; gi < `RSI_NCOND; gi = gi + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          cond_q[gi] <= 1'b0;
        end else begin
          s1_q <= cond_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            cond_q[gi] <= s3_q;
          end
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Shared timebase.
  // ---------------------------------------------------------------------------
  rsi_timebase #(
    .BLINK_HALF_CYC(BLINK_HALF_CYC),
    .PULSE_CYC(PULSE_CYC)
  ) u_timebase (
    .hclk(hclk),
    .hresetn(hresetn),
    .blink_q(blink),
    .pulse_q(pulse)
  );

  // Remote on/off applies only when software has remote control enabled; the
  // synchroniser resets low, so the output starts on until the pin is seen.
  assign remote_off = ctrl_q[`RSI_CTRL_REMOTE_EN] & cond_q[`RSI_C_REMOTE_OFF_N];

  // ---------------------------------------------------------------------------
  // Priority resolution of the indication state.
  // ---------------------------------------------------------------------------
  always @* begin
    state_d = ST_OK;
    if (cond_q[`RSI_C_IN_ABSENT]) begin
      state_d = ST_ABSENT;
    end else if (cond_q[`RSI_C_THERM_SHDN] | cond_q[`RSI_C_FUSE_BLOWN] |
                 cond_q[`RSI_C_BOOST_FAIL] | cond_q[`RSI_C_OV_LATCH]) begin
      state_d = ST_SHDN;
    end else if (cond_q[`RSI_C_IN_LIMITS]) begin
      state_d = ST_LIMITS;
    end else if (remote_off) begin
      state_d = ST_STBY;
    end else if (cond_q[`RSI_C_NONCAT] | cond_q[`RSI_C_FAN_FAIL]) begin
      state_d = ST_NONCAT;
    end else if (cond_q[`RSI_C_OVERLOAD]) begin
      state_d = ST_OVLD;
    end else if (cond_q[`RSI_C_THERM_ALARM]) begin
      state_d = ST_TALARM;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_OK;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Lamp and line decode from the resolved state.
  // ---------------------------------------------------------------------------
  always @* begin
    in_lamp_d = 1'b1;
    out_lamp_d = 1'b1;
    flt_lamp_d = 1'b0;
    fault_low_d = 1'b0;
    warn_low_d = 1'b0;
    stop_req = 1'b0;
    case (state_q)
      ST_OK: begin
        in_lamp_d = 1'b1;
      end
      ST_TALARM: begin
        flt_lamp_d = blink;
      end
      ST_SHDN: begin
        out_lamp_d = 1'b0;
        flt_lamp_d = 1'b1;
        fault_low_d = 1'b1;
        warn_low_d = 1'b1;
        stop_req = 1'b1;
      end
      ST_LIMITS: begin
        in_lamp_d = blink;
        out_lamp_d = 1'b0;
      end
      ST_ABSENT: begin
        in_lamp_d = 1'b0;
        out_lamp_d = 1'b0;
        warn_low_d = 1'b1;
        stop_req = 1'b1;
      end
      ST_OVLD: begin
        out_lamp_d = blink;
        warn_low_d = pulse;
      end
      ST_NONCAT: begin
        flt_lamp_d = 1'b1;
        fault_low_d = 1'b1;
      end
      ST_STBY: begin
        out_lamp_d = 1'b0;
        warn_low_d = 1'b1;
        stop_req = 1'b1;
      end
      default: begin
        in_lamp_d = 1'b1;
      end
    endcase
    // Lamp test overrides the lamps only; monitoring lines stay truthful.
    if (ctrl_q[`RSI_CTRL_LAMP_TEST]) begin
      in_lamp_d = 1'b1;
      out_lamp_d = 1'b1;
      flt_lamp_d = 1'b1;
    end
  end

  assign hot_low = cond_q[`RSI_C_THERM_ALARM] | cond_q[`RSI_C_THERM_SHDN];

  // ---------------------------------------------------------------------------
  // Power-fail lead: the warning drops at once, the output a lead time later.
  // ---------------------------------------------------------------------------
  // Holding the output up for the lead time even on a shutdown fault trades a
  // short delay in protection for advance notice to the shelf controller.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lead_cnt_q <= 32'h00000000;
      main_output_on <= 1'b1;
    end else if (!stop_req) begin
      lead_cnt_q <= 32'h00000000;
      main_output_on <= 1'b1;
    end else if (lead_cnt_q >= WARN_LEAD_CYC - 1) begin
      main_output_on <= 1'b0;
    end else begin
      lead_cnt_q <= lead_cnt_q + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------------------
  // Registered lamps and open-drain drivers.
  // ---------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      input_good_lamp <= 1'b0;
      output_good_lamp <= 1'b0;
      fault_lamp <= 1'b0;
      fault_n_o <= 1'b0;
      fault_n_oe <= 1'b0;
      power_fail_warning_n_o <= 1'b0;
      power_fail_warning_n_oe <= 1'b0;
      over_temp_warning_n_o <= 1'b0;
      over_temp_warning_n_oe <= 1'b0;
      power_capacity_n_o <= 1'b0;
      power_capacity_n_oe <= 1'b0;
      module_present_n_o <= 1'b0;
      module_present_n_oe <= 1'b1;
    end else begin
      input_good_lamp <= in_lamp_d;
      output_good_lamp <= out_lamp_d;
      fault_lamp <= flt_lamp_d;
      // Drivers only ever pull low; released lines float high externally.
      fault_n_o <= 1'b0;
      fault_n_oe <= fault_low_d;
      power_fail_warning_n_o <= 1'b0;
      power_fail_warning_n_oe <= warn_low_d;
      over_temp_warning_n_o <= 1'b0;
      over_temp_warning_n_oe <= hot_low;
      power_capacity_n_o <= 1'b0;
      power_capacity_n_oe <= cond_q[`RSI_C_OVERLOAD];
      module_present_n_o <= 1'b0;
      module_present_n_oe <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY.
  // ---------------------------------------------------------------------------
  assign addr_acc = hsel & htrans[1] & hready;

  assign ind_word = {21'h00000, state_q, main_output_on, power_capacity_n_oe, over_temp_warning_n_oe,
                     power_fail_warning_n_oe, fault_n_oe, fault_lamp, output_good_lamp, input_good_lamp};

  // Read data are chosen in the address phase and stand in the data phase.
  always @* begin
    case (haddr[11:0])
      `RSI_OFF_CTRL: rd_mux = ctrl_q;
      `RSI_OFF_COND: rd_mux = {{(32-`RSI_NCOND){1'b0}}, cond_q};
      `RSI_OFF_IND: rd_mux = ind_word;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_acc & hwrite;
      if (addr_acc) begin
        wr_addr_q <= haddr[11:0];
      end
      if (addr_acc & !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Control register write lands in the data phase; other offsets ignore writes.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= `RSI_CTRL_RESET;
    end else if (wr_pend_q && wr_addr_q == `RSI_OFF_CTRL) begin
      ctrl_q <= {30'h0000000, hwdata[`RSI_CTRL_LAMP_TEST], hwdata[`RSI_CTRL_REMOTE_EN]};
    end
  end

endmodule

/* core/rsi_defines.vh */
// Constants for the rectifier status indicator: register map, field positions,
// reset values and timing figures.
// Assumes inclusion by bare name from the core folder.
`ifndef RSI_DEFINES_VH
`define RSI_DEFINES_VH

// ----------------------------------------------------------------------------
// Register byte offsets on the AHB-Lite slave.
// ----------------------------------------------------------------------------
`define RSI_OFF_CTRL 12'h000
`define RSI_OFF_COND 12'h004
`define RSI_OFF_IND 12'h008

// ----------------------------------------------------------------------------
// Control register fields and reset value.
// ----------------------------------------------------------------------------
`define RSI_CTRL_REMOTE_EN 0
`define RSI_CTRL_LAMP_TEST 1
`define RSI_CTRL_RESET 32'h00000001

// ----------------------------------------------------------------------------
// Condition vector bit positions (also the layout of the condition register).
// ----------------------------------------------------------------------------
`define RSI_C_THERM_ALARM 0
`define RSI_C_THERM_SHDN 1
`define RSI_C_FAN_FAIL 2
`define RSI_C_FUSE_BLOWN 3
`define RSI_C_BOOST_FAIL 4
`define RSI_C_OV_LATCH 5
`define RSI_C_IN_LIMITS 6
`define RSI_C_IN_ABSENT 7
`define RSI_C_OVERLOAD 8
`define RSI_C_NONCAT 9
`define RSI_C_REMOTE_OFF_N 10
`define RSI_NCOND 11

// ----------------------------------------------------------------------------
// Indication register fields.
// ----------------------------------------------------------------------------
`define RSI_I_IN_LAMP 0
`define RSI_I_OUT_LAMP 1
`define RSI_I_FLT_LAMP 2
`define RSI_I_FAULT_N 3
`define RSI_I_WARN_N 4
`define RSI_I_HOT_N 5
`define RSI_I_CAP_N 6
`define RSI_I_OUT_ON 7
`define RSI_I_STATE_LSB 8

// ----------------------------------------------------------------------------
// Timing figures in their own units and the clock rate.
// ----------------------------------------------------------------------------
`define RSI_CLK_HZ 20000000
`define RSI_WARN_LEAD_US 5000
`define RSI_PULSE_US 1000
`define RSI_BLINK_HALF_MS 500

`endif

/* core/rsi_timebase.v */
// Free-running timebase: a lamp blink square wave and the overload pulse wave.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns

module rsi_timebase #(
  parameter BLINK_HALF_CYC = 10000000,
  parameter PULSE_CYC = 20000
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Waves.
  output reg blink_q,
  output reg pulse_q
);

  reg [31:0] blink_cnt_q;
  reg [31:0] pulse_cnt_q;

  // ---------------------------------------------------------------------------
  // Blink wave, one rate shared by every lamp.
  // ---------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_cnt_q <= 32'h00000000;
      blink_q <= 1'b0;
    end else if (blink_cnt_q >= BLINK_HALF_CYC - 1) begin
      blink_cnt_q <= 32'h00000000;
      blink_q <= ~blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h00000001;
    end
  end

  // ---------------------------------------------------------------------------
  // Pulse wave: one millisecond low, one millisecond high.
  // ---------------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt_q <= 32'h00000000;
      pulse_q <= 1'b0;
    end else if (pulse_cnt_q >= PULSE_CYC - 1) begin
      pulse_cnt_q <= 32'h00000000;
      pulse_q <= ~pulse_q;
    end else begin
      pulse_cnt_q <= pulse_cnt_q + 32'h00000001;
    end
  end

endmodule

/* tb/rsi_status_assertions.sv */
// Checker for the status indicator's lamps and monitoring lines.
// Assumes it is bound onto rsi_status and sees only that module's ports.
`timescale 1ns/1ns

module rsi_status_assertions #(
  parameter WARN_LEAD_CYC = 100000
) (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Lamps and main output.
  input wire input_good_lamp,
  input wire output_good_lamp,
  input wire fault_lamp,
  input wire main_output_on,
  // Open-drain lines.
  input wire fault_n_o,
  input wire fault_n_oe,
  input wire power_fail_warning_n_o,
  input wire power_fail_warning_n_oe,
  input wire over_temp_warning_n_o,
  input wire power_capacity_n_o,
  input wire power_capacity_n_oe,
  input wire module_present_n_o,
  input wire module_present_n_oe
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // --------------------------------------------------------------------------
  // Helper logic
  // --------------------------------------------------------------------------
  // Cycles the warning has stood; saturates so a long standby cannot wrap it.
  reg [31:0] lead_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lead_q <= 32'h00000000;
    end else if (!power_fail_warning_n_oe) begin
      lead_q <= 32'h00000000;
    end else if (lead_q != 32'hFFFFFFFF) begin
      lead_q <= lead_q + 32'h00000001;
    end
  end

  // A warning pulse starting inside a running overload, then its hold. The
  // pulse phase runs free, so the pulse caught at overload entry may be short.
  sequence s_pulse_start;
    $past(power_capacity_n_oe, 2) && power_capacity_n_oe && $rose(power_fail_warning_n_oe);
  endsequence
  sequence s_pulse_hold;
    (power_fail_warning_n_oe || !power_capacity_n_oe) [*3];
  endsequence

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  a_lines_pull_only: assert property (
    !fault_n_o && !power_fail_warning_n_o && !over_temp_warning_n_o && !power_capacity_n_o)
    else $error("open-drain line driven high");
  a_present_held_low: assert property (module_present_n_oe && !module_present_n_o)
    else $error("presence line released");
  a_warning_lead_time: assert property ($fell(main_output_on) |-> lead_q >= WARN_LEAD_CYC - 1)
    else $error("output dropped without warning lead");
  a_pulse_min_width: assert property (s_pulse_start |=> s_pulse_hold)
    else $error("overload pulse too short");
  a_dark_input_quiet: assert property (
    !input_good_lamp |-> !output_good_lamp && !fault_lamp && !fault_n_oe)
    else $error("lamps or fault line wrong with input lamp dark");
  a_fault_lamp_lit: assert property (fault_n_oe |-> fault_lamp)
    else $error("fault line low but fault lamp dark");
  a_shutdown_warns: assert property (fault_n_oe && !output_good_lamp |-> power_fail_warning_n_oe)
    else $error("shutdown without warning");
  a_overload_no_fault: assert property (power_capacity_n_oe && !fault_n_oe |-> !fault_lamp)
    else $error("overload shows a fault");
endmodule

bind rsi_status rsi_status_assertions #(.WARN_LEAD_CYC(WARN_LEAD_CYC)) u_rsi_chk (
  .hclk(hclk), .hresetn(hresetn), .input_good_lamp(input_good_lamp), .output_good_lamp(output_good_lamp),
  .fault_lamp(fault_lamp), .main_output_on(main_output_on), .fault_n_o(fault_n_o), .fault_n_oe(fault_n_oe),
  .power_fail_warning_n_o(power_fail_warning_n_o), .power_fail_warning_n_oe(power_fail_warning_n_oe),
  .over_temp_warning_n_o(over_temp_warning_n_o), .power_capacity_n_o(power_capacity_n_o),
  .power_capacity_n_oe(power_capacity_n_oe), .module_present_n_o(module_present_n_o),
  .module_present_n_oe(module_present_n_oe));

/* tb/rsi_shelf_ctrl.sv */
// Shelf controller model: pull-ups on the monitoring lines, remote contact.
// Assumes the module pulls a line low only while its enable is high.
`timescale 1ns/1ns

module rsi_shelf_ctrl (
  // Enables from the module.
  input wire fault_oe,
  input wire warn_oe,
  input wire hot_oe,
  input wire cap_oe,
  input wire pres_oe,
  // Standby request from the bench.
  input wire standby_req,
  // Lines as seen here.
  output wire fault_ln,
  output wire warn_ln,
  output wire hot_ln,
  output wire cap_ln,
  output wire pres_ln,
  output wire remote_on_off_n
);
  // A released line floats up to the pull-up, never holds its last level.
  assign fault_ln = fault_oe ? 1'b0 : 1'b1;
  assign warn_ln = warn_oe ? 1'b0 : 1'b1;
  assign hot_ln = hot_oe ? 1'b0 : 1'b1;
  assign cap_ln = cap_oe ? 1'b0 : 1'b1;
  assign pres_ln = pres_oe ? 1'b0 : 1'b1;
  // Contact grounded asks for output on; open contact reads high.
  assign remote_on_off_n = standby_req ? 1'b1 : 1'b0;
endmodule

/* tb/rsi_status_bench.sv */
// Self-checking bench for the rectifier status indicator.
// Assumes the design, checker and shelf controller model compile first.
`timescale 1ns/1ns

module rsi_status_bench;
  localparam [1:0] LO = 2'h2;
  localparam [1:0] HI = 2'h1;
  localparam [1:0] TG = 2'h3;
  reg hclk;
  reg hresetn;
  reg hsel;
  reg [31:0] haddr;
  reg [1:0] htrans;
  reg hwrite;
  reg [2:0] hsize;
  reg [31:0] hwdata;
  reg [10:0] cv;
  reg [31:0] rd;
  integer n_errors;
  integer checked;
  wire hreadyout, hresp, in_l, out_l, flt_l, main_on, rmt_n;
  wire [31:0] hrdata;
  wire f_oe, warn_oe, hot_oe, cap_oe, pres_oe, f_ln, warn_ln, hot_ln, cap_ln, pres_ln;

  // Short counts keep blink, pulse and lead visible within a few cycles.
  rsi_status #(.WARN_LEAD_CYC(20), .PULSE_CYC(4), .BLINK_HALF_CYC(8)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .thermal_alarm(cv[0]), .thermal_shutdown(cv[1]), .fan_fail(cv[2]), .fuse_blown(cv[3]), .boost_fail(cv[4]),
    .ov_latched(cv[5]), .input_out_of_limits(cv[6]), .input_absent(cv[7]), .overload(cv[8]),
    .noncat_fail(cv[9]), .remote_on_off_n(rmt_n), .input_good_lamp(in_l), .output_good_lamp(out_l),
    .fault_lamp(flt_l), .fault_n_o(), .fault_n_oe(f_oe), .power_fail_warning_n_o(),
    .power_fail_warning_n_oe(warn_oe), .over_temp_warning_n_o(), .over_temp_warning_n_oe(hot_oe),
    .power_capacity_n_o(), .power_capacity_n_oe(cap_oe), .module_present_n_o(),
    .module_present_n_oe(pres_oe), .main_output_on(main_on));

  rsi_shelf_ctrl u_shelf (
    .fault_oe(f_oe), .warn_oe(warn_oe), .hot_oe(hot_oe), .cap_oe(cap_oe), .pres_oe(pres_oe),
    .standby_req(cv[10]), .fault_ln(f_ln), .warn_ln(warn_ln), .hot_ln(hot_ln), .cap_ln(cap_ln),
    .pres_ln(pres_ln), .remote_on_off_n(rmt_n));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      checked = checked + 1;
      if (g !== e) begin
        n_errors = n_errors + 1;
        $display("wrong value %s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  // One word transfer; the master never assumes the slave's wait count.
  task ahb(input w, input [31:0] a, input [31:0] wd);
    begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask

  // Applies conditions, records what each lamp and the fault and warning lines did, then clears.
  task row(input [10:0] c, input [1:0] ei, eo, ef, efl, epl, input emo);
    reg [4:0] s1;
    reg [4:0] s0;
    reg [4:0] v;
    integer i;
    begin
      @(posedge hclk);
      cv <= c;
      repeat (10) @(posedge hclk);
      s1 = 5'h00;
      s0 = 5'h00;
      repeat (32) begin
        @(negedge hclk);
        v = {in_l, out_l, flt_l, f_ln, warn_ln};
        for (i = 0; i < 5; i = i + 1) begin
          if (v[i] === 1'b1) s1[i] = 1'b1;
          if (v[i] === 1'b0) s0[i] = 1'b1;
        end
      end
      chk("lamps and lines", {ei, eo, ef, efl, epl},
        {s0[4], s1[4], s0[3], s1[3], s0[2], s1[2], s0[1], s1[1], s0[0], s1[0]});
      chk("main output", emo, main_on);
      chk("over-temp line", {31'h0, !(c[0] | c[1])}, hot_ln);
      chk("capacity line", {31'h0, !c[8]}, cap_ln);
      @(posedge hclk);
      cv <= 11'h000;
      repeat (12) @(posedge hclk);
    end
  endtask

  task t_quiet;
    begin
      row(11'h000, HI, HI, LO, HI, HI, 1'b1);
      chk("presence line", 32'h0, pres_ln);
      $display("test quiet done");
    end
  endtask

  task t_single;
    begin
      row(11'h001, HI, HI, TG, HI, HI, 1'b1);
      row(11'h002, HI, LO, HI, LO, LO, 1'b0);
      row(11'h008, HI, LO, HI, LO, LO, 1'b0);
      row(11'h010, HI, LO, HI, LO, LO, 1'b0);
      row(11'h020, HI, LO, HI, LO, LO, 1'b0);
      row(11'h040, TG, LO, LO, HI, HI, 1'b1);
      row(11'h080, LO, LO, LO, HI, LO, 1'b0);
      row(11'h100, HI, TG, LO, HI, TG, 1'b1);
      row(11'h200, HI, HI, HI, LO, HI, 1'b1);
      row(11'h004, HI, HI, HI, LO, HI, 1'b1);
      row(11'h400, HI, LO, LO, HI, LO, 1'b0);
      $display("test single conditions done");
    end
  endtask

  task t_priority;
    begin
      row(11'h182, LO, LO, LO, HI, LO, 1'b0);
      row(11'h303, HI, LO, HI, LO, LO, 1'b0);
      row(11'h301, HI, HI, HI, LO, HI, 1'b1);
      $display("test priority done");
    end
  endtask

  task t_regs;
    begin
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl reset", 32'h00000001, rd);
      chk("response", 32'h0, hresp);
      ahb(1'b0, 32'hC, 32'h0);
      chk("unmapped read", 32'h00000000, rd);
      ahb(1'b1, 32'h4, 32'hFFFFFFFF);
      ahb(1'b0, 32'h4, 32'h0);
      chk("cond read", 32'h00000000, rd);
      ahb(1'b0, 32'h8, 32'h0);
      chk("ind read", 32'h00000083, rd);
      ahb(1'b1, 32'h0, 32'h3);
      ahb(1'b0, 32'h0, 32'h0);
      chk("ctrl readback", 32'h00000003, rd);
      repeat (4) @(posedge hclk);
      chk("lamp test", 32'h7, {in_l, out_l, flt_l});
      ahb(1'b1, 32'h0, 32'h0);
      cv <= 11'h400;
      repeat (42) @(posedge hclk);
      chk("remote disabled", 32'h1, main_on);
      cv <= 11'h000;
      ahb(1'b1, 32'h0, 32'h1);
      $display("test registers done");
    end
  endtask

  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cv = 11'h000;
    n_errors = 0;
    checked = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_quiet;
    t_single;
    t_priority;
    t_regs;
    end_sim;
  end

  // Whole run needs about a thousand cycles; five thousand means a hang.
  initial begin
    #250000;
    n_errors = n_errors + 1;
    $display("watchdog expired");
    end_sim;
  end
endmodule
